// file: hdl/bridge_fault_diag_regs.v
// Fault diagnosis, identifier and version registers of the bridge,
// read over a four-wire serial link sampled by clk_sys.
// Assumes serial clock well below clk_sys/4; fault inputs are pins.
//
// Operation
// - Bit 7 live: enable high, shutdown low
// - Bit 4 latched low on current limit
// - Bit 5 latched low on thermal reduction
// - Bit 6 latched low on overtemperature
// - Output A code: 01 supply, 10 ground
// - Output B code: 01 supply, 10 ground
// - Load short 1100, open load 0011, latched
// - Undervoltage forces low nibble 0000, live
// - Show highest priority stored fault class, A and B codes together
// - Stored faults reappear after undervoltage ends
// - Clear after full 16-pulse diagnosis read
// - Clear when mode supply rises past threshold
// - Enable rise (shutdown low) or shutdown fall (enable high) reactivate and clear
// - Fixed read-only identifier byte
// - Version byte: release high, mask low
// - Open load checked only disabled, serial mode
// - A high, B low means open load
`default_nettype none
`include "diag_defines.vh"

module bridge_fault_diag_regs #(
    parameter [7:0] DEVICE_IDENTIFIER   = 8'h5a, // Arbitrary value
    parameter [3:0] RELEASE_REV = 4'h1,  // Arbitrary value
    parameter [3:0] MASK_REV    = 4'h2   // Arbitrary value
) (
    // Clock, reset, enable
    input  wire clk_sys,
    input  wire rst,
    input  wire ce,
    // Serial link
    input  wire sck,
    input  wire csN,
    input  wire sdi,
    output reg  sdo,
    output reg  sdoEn,
    // Bridge control pins
    input  wire enable,
    input  wire shutdownRequest,
    output wire bridgeActiveFlag,
    output reg  reactivate,
    // Supply conditions
    input  wire mainSupplyUnder,
    input  wire diagModeSelect,
    input  wire diagModeFull,
    // Fault events
    input  wire currentLimit,
    input  wire thermalReduction,
    input  wire overTemp,
    input  wire shortAcrossLoad,
    input  wire outAShortToSupply,
    input  wire outAShortToGround,
    input  wire outBShortToSupply,
    input  wire outBShortToGround,
    // Output sense in off state
    input  wire outASense,
    input  wire outBSense
);
    localparam NIN = 18;

    wire [NIN-1:0] rawIn;
    wire [NIN-1:0] syncIn;

    wire sckS;
    wire csNS;
    wire sdiS;
    wire enS;
    wire shutS;
    wire uvS;
    wire dmsS;
    wire dmsFullS;
    wire limS;
    wire redS;
    wire otS;
    wire scolS;
    wire aScbS;
    wire aScgS;
    wire bScbS;
    wire bScgS;
    wire aSenseS;
    wire bSenseS;

    // Edge history
    reg sckPrev_q;
    reg csNPrev_q;
    reg enPrev_q;
    reg shutPrev_q;
    reg dmsPrev_q;
    reg [1:0] settle_q;

    // Stored faults
    reg curLimit_q;
    reg thermRed_q;
    reg overTemp_q;
    reg short_across_load_q;
    reg aScb_q;
    reg aScg_q;
    reg bScb_q;
    reg bScg_q;
    reg openLoad_q;

    // Serial engine
    reg [4:0] bitCnt_q;
    reg [7:0] rxShift_q;
    reg [7:0] txShift_q;
    reg [7:0] snapshot_q;
    reg [7:0] instr_q;
    reg       instrDone_q;

    wire       sckRise;
    wire       sckFall;
    wire       frameStart;
    wire       frameEnd;
    wire       enRise;
    wire       shutFall;
    wire       dmsRise;
    wire       bridgeDisabled;
    wire       openLoadSeen;
    wire       instrDiagRead;
    wire       clearDiag;
    wire       fullReadEnd;
    wire       reactCond;
    wire       addrOk;
    wire       instrLast;
    wire       shiftWindow;
    wire       settled;
    wire [3:0] nibble;
    wire [7:0] diagByte;
    wire [7:0] versionByte;
    wire [7:0] rxByte;
    reg  [7:0] txByte;

    assign rawIn = {sck, csN, sdi, enable, shutdownRequest, mainSupplyUnder,
                    diagModeSelect, diagModeFull, currentLimit,
                    thermalReduction, overTemp, shortAcrossLoad,
                    outAShortToSupply, outAShortToGround, outBShortToSupply,
                    outBShortToGround, outASense, outBSense};

    sync2 #(
        .W (NIN)
    ) uSync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .asyncIn (rawIn),
        .syncOut (syncIn)
    );

    // Synchronised pins
    assign sckS     = syncIn[17];
    assign csNS     = syncIn[16];
    assign sdiS     = syncIn[15];
    assign enS      = syncIn[14];
    assign shutS    = syncIn[13];
    assign uvS      = syncIn[12];
    assign dmsS     = syncIn[11];
    assign dmsFullS = syncIn[10];
    assign limS     = syncIn[9];
    assign redS     = syncIn[8];
    assign otS      = syncIn[7];
    assign scolS    = syncIn[6];
    assign aScbS    = syncIn[5];
    assign aScgS    = syncIn[4];
    assign bScbS    = syncIn[3];
    assign bScgS    = syncIn[2];
    assign aSenseS  = syncIn[1];
    assign bSenseS  = syncIn[0];

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sckPrev_q  <= 1'b0;
            csNPrev_q  <= 1'b1;
            enPrev_q   <= 1'b0;
            shutPrev_q <= 1'b0;
            dmsPrev_q  <= 1'b0;
        end else if (ce) begin
            sckPrev_q  <= sckS;
            csNPrev_q  <= csNS;
            enPrev_q   <= enS;
            shutPrev_q <= shutS;
            dmsPrev_q  <= dmsS;
        end
    end

    // Edges held off until synchronisers and history fill
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            settle_q <= 2'h0;
        end else if (ce && !settled) begin
            settle_q <= settle_q + 2'h1;
        end
    end

    assign settled    = (settle_q == 2'h3);
    assign sckRise    = settled & sckS & ~sckPrev_q & ~csNS;
    assign sckFall    = settled & ~sckS & sckPrev_q & ~csNS;
    assign frameStart = settled & ~csNS & csNPrev_q;
    assign frameEnd   = settled & csNS & ~csNPrev_q;
    assign enRise     = settled & enS & ~enPrev_q;
    assign shutFall   = settled & ~shutS & shutPrev_q;
    assign dmsRise    = settled & dmsS & ~dmsPrev_q;

    // Bridge state
    assign bridgeActiveFlag = enS & ~shutS;
    assign bridgeDisabled   = ~bridgeActiveFlag;

    // Off-state open load check
    assign openLoadSeen = dmsS & dmsFullS & bridgeDisabled &
                          aSenseS & ~bSenseS;

    // Register clear sources
    assign instrDiagRead = instrDone_q & (instr_q == `DIAG_INSTR_DIAG);
    assign fullReadEnd   = frameEnd & instrDiagRead &
                           (bitCnt_q == `DIAG_FRAME_BITS);
    assign reactCond     = (enRise & ~shutS) |
                           (shutFall & enS);
    assign clearDiag     = fullReadEnd |
                           dmsRise |
                           reactCond;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reactivate <= 1'b0;
        end else if (ce) begin
            reactivate <= reactCond;
        end
    end

    // Sticky faults, a new event wins over a clear
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            curLimit_q <= `DIAG_FLAG_RESET;
            thermRed_q <= `DIAG_FLAG_RESET;
            overTemp_q <= `DIAG_FLAG_RESET;
            short_across_load_q     <= `DIAG_FLAG_RESET;
            aScb_q     <= `DIAG_FLAG_RESET;
            aScg_q     <= `DIAG_FLAG_RESET;
            bScb_q     <= `DIAG_FLAG_RESET;
            bScg_q     <= `DIAG_FLAG_RESET;
            openLoad_q <= `DIAG_FLAG_RESET;
        end else if (ce) begin
            curLimit_q <= limS | (curLimit_q & ~clearDiag);
            thermRed_q <= redS | (thermRed_q & ~clearDiag);
            overTemp_q <= otS | (overTemp_q & ~clearDiag);
            short_across_load_q     <= scolS | (short_across_load_q & ~clearDiag);
            aScb_q     <= aScbS | (aScb_q & ~clearDiag);
            aScg_q     <= aScgS | (aScg_q & ~clearDiag);
            bScb_q     <= bScbS | (bScb_q & ~clearDiag);
            bScg_q     <= bScgS | (bScg_q & ~clearDiag);
            openLoad_q <= openLoadSeen | (openLoad_q & ~clearDiag);
        end
    end

    // Stored flags stay put under undervoltage
    diag_encoder uEnc (
        .underVolt         (uvS),
        .shortAcrossLoad   (short_across_load_q),
        .outAShortToSupply (aScb_q),
        .outAShortToGround (aScg_q),
        .outBShortToSupply (bScb_q),
        .outBShortToGround (bScg_q),
        .openLoad          (openLoad_q),
        .nibble            (nibble)
    );

    // Diagnosis byte
    assign diagByte = {bridgeActiveFlag, ~overTemp_q, ~thermRed_q,
                       ~curLimit_q, nibble};
    assign versionByte = {RELEASE_REV, MASK_REV};
    assign rxByte = {rxShift_q[6:0], sdiS};

    // Frame position helpers
    assign addrOk      = (rxByte[7:6] == `DIAG_ADDR_OK);
    assign instrLast   = (bitCnt_q == `DIAG_BYTE_BITS - 5'd1);
    assign shiftWindow = (bitCnt_q > `DIAG_BYTE_BITS) &&
                         (bitCnt_q < `DIAG_FRAME_BITS);

    // Data byte selected by the instruction
    always @* begin
        case (rxByte)
            `DIAG_INSTR_IDENT: begin
                txByte = DEVICE_IDENTIFIER;
            end
            `DIAG_INSTR_VERSION: begin
                txByte = versionByte;
            end
            `DIAG_INSTR_DIAG: begin
                txByte = snapshot_q;
            end
            default: begin
                txByte = `DIAG_UNUSED_DATA;
            end
        endcase
    end

    // Serial engine
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bitCnt_q    <= 5'd0;
            rxShift_q   <= 8'h00;
            txShift_q   <= 8'h00;
            snapshot_q  <= 8'h00;
            instr_q     <= 8'h00;
            instrDone_q <= 1'b0;
            sdo         <= 1'b0;
            sdoEn       <= 1'b0;
        end else if (ce) begin
            if (frameStart) begin
                bitCnt_q    <= 5'd0;
                rxShift_q   <= 8'h00;
                instrDone_q <= 1'b0;
                snapshot_q  <= diagByte;
                sdoEn       <= 1'b0;
            end else if (frameEnd) begin
                sdoEn       <= 1'b0;
                instrDone_q <= 1'b0;
            end else if (sckRise) begin
                if (bitCnt_q != `DIAG_CNT_MAX) begin
                    bitCnt_q <= bitCnt_q + 5'd1;
                end
                rxShift_q <= rxByte;
                if (instrLast) begin
                    instr_q     <= rxByte;
                    instrDone_q <= 1'b1;
                    txShift_q   <= {txByte[6:0], 1'b0};
                    sdo         <= txByte[7];
                    sdoEn       <= addrOk;
                end
            end else if (sckFall) begin
                if (shiftWindow) begin
                    sdo       <= txShift_q[7];
                    txShift_q <= {txShift_q[6:0], 1'b0};
                end else if (bitCnt_q >= `DIAG_FRAME_BITS) begin
                    sdoEn <= 1'b0;
                end
            end
        end
    end
endmodule // bridge_fault_diag_regs

`default_nettype wire

// file: hdl/diag_defines.vh
// Constants of the bridge fault diagnosis register set
// Assumes inclusion by bare name from the design files
`ifndef DIAG_DEFINES_VH
`define DIAG_DEFINES_VH

// Instruction bytes, chip address in bits 7:6
`define DIAG_INSTR_IDENT    8'h00
`define DIAG_INSTR_VERSION  8'h03
`define DIAG_INSTR_DIAG     8'h09
`define DIAG_ADDR_OK        2'h0
`define DIAG_UNUSED_DATA    8'hff

// Frame counts in serial clock pulses
`define DIAG_BYTE_BITS      5'd8
`define DIAG_FRAME_BITS     5'd16
`define DIAG_CNT_MAX        5'd31

// Diagnosis byte field positions
`define DIAG_BIT_ACTIVE     7
`define DIAG_BIT_OVERTEMP   6
`define DIAG_BIT_THERM_RED  5
`define DIAG_BIT_CUR_LIM    4

// Per-output codes and whole-nibble codes
`define DIAG_CODE_SUPPLY    2'h1
`define DIAG_CODE_GROUND    2'h2
`define DIAG_CODE_NONE      2'h3
`define DIAG_NIB_SHORT_ACROSS_LOAD       4'hc
`define DIAG_NIB_OPEN       4'h3
`define DIAG_NIB_UNDERVOLT  4'h0
`define DIAG_NIB_CLEAN      4'hf

// Reset value of the stored flags
`define DIAG_FLAG_RESET     1'b0

`endif

// file: hdl/sync2.v
// Two-flop synchroniser, one pair per bit
// Assumes asynchronous inputs and a free-running clk_sys
`default_nettype none

module sync2 #(
    parameter W = 1
) (
    // Clock, reset, enable
    input  wire         clk_sys,
    input  wire         rst,
    input  wire         ce,
    // Data
    input  wire [W-1:0] asyncIn,
    output wire [W-1:0] syncOut
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : gBit
            reg meta_q;
            reg stable_q;
            always @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    meta_q   <= 1'b0;
                    stable_q <= 1'b0;
                end else if (ce) begin
                    meta_q   <= asyncIn[i];
                    stable_q <= meta_q;
                end
            end
            assign syncOut[i] = stable_q;
        end
    endgenerate
endmodule // sync2

`default_nettype wire

// file: hdl/diag_encoder.v
// Priority encoder for the low nibble of the diagnosis byte
// Assumes stored flags from the register bank, same clock
`default_nettype none
`include "diag_defines.vh"

module diag_encoder (
    // Live and stored conditions
    input  wire       underVolt,
    input  wire       shortAcrossLoad,
    input  wire       outAShortToSupply,
    input  wire       outAShortToGround,
    input  wire       outBShortToSupply,
    input  wire       outBShortToGround,
    input  wire       openLoad,
    // Encoded nibble
    output reg  [3:0] nibble
);
    reg [1:0] codeA;
    reg [1:0] codeB;

    always @* begin
        codeA = outAShortToSupply ? `DIAG_CODE_SUPPLY :
                outAShortToGround ? `DIAG_CODE_GROUND : `DIAG_CODE_NONE;
        codeB = outBShortToSupply ? `DIAG_CODE_SUPPLY :
                outBShortToGround ? `DIAG_CODE_GROUND : `DIAG_CODE_NONE;
        if (underVolt) begin
            nibble = `DIAG_NIB_UNDERVOLT;
        end else if (shortAcrossLoad) begin
            nibble = `DIAG_NIB_SHORT_ACROSS_LOAD;
        end else if (outAShortToSupply | outAShortToGround |
                     outBShortToSupply | outBShortToGround) begin
            nibble = {codeB, codeA};
        end else if (openLoad) begin
            nibble = `DIAG_NIB_OPEN;
        end else begin
            nibble = `DIAG_NIB_CLEAN;
        end
    end
endmodule // diag_encoder

`default_nettype wire

// file: dv/bridge_fault_diag_regs_properties.sv
// Port checks for the fault diagnosis register set
// Assumes clk_sys only and an asynchronous active-high rst
`default_nettype none

module bridge_fault_diag_regs_checker (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Serial link
    input wire logic sck,
    input wire logic csN,
    input wire logic sdo,
    input wire logic sdoEn,
    // Bridge control
    input wire logic enable,
    input wire logic shutdownRequest,
    input wire logic bridgeActiveFlag,
    input wire logic reactivate
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    AST_ACTIVE_ON: assert property ((enable && !shutdownRequest)[*3]
        |-> bridgeActiveFlag) else $error("active flag low while enabled");
    AST_ACTIVE_OFF_EN: assert property ((!enable)[*3] |-> !bridgeActiveFlag)
        else $error("active flag high with enable low");
    AST_ACTIVE_OFF_SD: assert property (shutdownRequest[*3] |-> !bridgeActiveFlag)
        else $error("active flag high during shutdown");
    AST_REACT_ON_RISE: assert property ($rose(bridgeActiveFlag)
        |-> ##[0:2] reactivate) else $error("no reactivation after bridge release");
    AST_REACT_PULSE: assert property (reactivate |=> !reactivate)
        else $error("reactivation pulse too long");
    AST_REACT_ACTIVE: assert property (reactivate |-> bridgeActiveFlag)
        else $error("reactivation while bridge disabled");
    AST_SDO_STABLE: assert property (sdoEn && $past(sdoEn) && sck && $past(sck)
        |-> $stable(sdo)) else $error("data out moved while clock high");
    AST_INSTR_QUIET: assert property ($fell(csN) |=> (!sdoEn)[*8])
        else $error("data out driven during instruction byte");
    AST_IDLE_QUIET: assert property (csN[*6] |-> !sdoEn)
        else $error("data out driven while deselected");
    AST_RESET_QUIET: assert property ($fell(rst) |-> !sdoEn && !reactivate)
        else $error("outputs active at reset release");
endmodule // bridge_fault_diag_regs_checker

bind bridge_fault_diag_regs bridge_fault_diag_regs_checker u_bridge_fault_diag_regs_checker (
    .clk_sys(clk_sys), .rst(rst), .sck(sck), .csN(csN), .sdo(sdo), .sdoEn(sdoEn),
    .enable(enable), .shutdownRequest(shutdownRequest),
    .bridgeActiveFlag(bridgeActiveFlag), .reactivate(reactivate)
);

`default_nettype wire

// file: dv/spi_host_model.sv
// Serial host: instruction byte out, answer byte in, MSB first
// Assumes clk_sys at 100 ns; link clock 800 ns, idle low outside frames
`default_nettype none

module spi_host_model (
    // Clock
    input  wire logic clk_sys,
    // Device answer
    input  wire logic sdo,
    input  wire logic sdoEn,
    // Serial link to device
    output var  logic sck,
    output var  logic csN,
    output var  logic sdi
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sck = 1'b0;
        csN = 1'b1;
        sdi = 1'b0;
    end

    // Half a link clock period
    task automatic half();
        repeat (4) @(posedge clk_sys);
        #1;
    endtask

    task automatic transfer(input logic [7:0] instr, input int n,
                            output logic [7:0] rx, output logic drove);
        rx = 8'h00;
        drove = 1'b0;
        csN = 1'b0;
        half();
        for (int i = 0; i < n; i++) begin
            sdi = (i < 8) ? instr[7 - i] : ~sdi;
            half();
            sck = 1'b1;
            if (i >= 8) begin
                // Released line reads as inverse
                rx = {rx[6:0], sdoEn ? sdo : ~sdo};
                drove = drove | sdoEn;
            end
            half();
            sck = 1'b0;
        end
        half();
        csN = 1'b1;
        repeat (2) half();
    endtask
endmodule // spi_host_model

`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the fault diagnosis register set
// Assumes the host model drives the serial link; ce held high
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [1:0] ctl;
        logic [1:0] sense;
        logic       uv;
        logic [7:0] ev;
        logic [7:0] exp;
    } row_t;
    localparam logic [7:0] ID_VAL   = 8'h3c; // Arbitrary value
    localparam logic [3:0] REL_VAL  = 4'h0;  // Arbitrary value
    localparam logic [3:0] MASK_VAL = 4'h7;  // Arbitrary value
    localparam int         LIMIT    = 20000;
    logic       clk_sys, rst, enable, shutdownRequest, mainSupplyUnder, diagModeSelect;
    logic       outASense, outBSense, diagModeFull, drove;
    logic [7:0] ev, rx;
    wire        sck, csN, sdi, sdo, sdoEn, bridgeActiveFlag, reactivate;
    int         mismatches, samplesChecked, cycles;
    logic [7:0] oddInstr[3] = '{8'h09, 8'h09, 8'h00};
    int         oddLen[3]   = '{15, 17, 16};
    row_t       rows[21]    = '{
        '{2'h2, 2'h3, 1'h0, 8'h00, 8'hff}, '{2'h0, 2'h3, 1'h0, 8'h00, 8'h7f},
        '{2'h1, 2'h3, 1'h0, 8'h00, 8'h7f}, '{2'h3, 2'h3, 1'h0, 8'h00, 8'h7f},
        '{2'h1, 2'h2, 1'h0, 8'h00, 8'h73}, '{2'h0, 2'h2, 1'h0, 8'h00, 8'h73},
        '{2'h0, 2'h2, 1'h0, 8'h04, 8'h7e}, '{2'h0, 2'h0, 1'h0, 8'h00, 8'h7f},
        '{2'h2, 2'h2, 1'h0, 8'h00, 8'hff}, '{2'h2, 2'h3, 1'h0, 8'h80, 8'hef},
        '{2'h2, 2'h3, 1'h0, 8'h40, 8'hdf}, '{2'h2, 2'h3, 1'h0, 8'h20, 8'hbf},
        '{2'h2, 2'h3, 1'h0, 8'he0, 8'h8f}, '{2'h2, 2'h3, 1'h0, 8'h08, 8'hfd},
        '{2'h2, 2'h3, 1'h0, 8'h04, 8'hfe}, '{2'h2, 2'h3, 1'h0, 8'h02, 8'hf7},
        '{2'h2, 2'h3, 1'h0, 8'h01, 8'hfb}, '{2'h2, 2'h3, 1'h0, 8'h10, 8'hfc},
        '{2'h2, 2'h3, 1'h0, 8'h19, 8'hfc}, '{2'h2, 2'h3, 1'h0, 8'h06, 8'hf6},
        '{2'h2, 2'h3, 1'h1, 8'h08, 8'hf0}};

    bridge_fault_diag_regs #(.DEVICE_IDENTIFIER(ID_VAL), .RELEASE_REV(REL_VAL), .MASK_REV(MASK_VAL))
    u_bridge_fault_diag_regs (
        .clk_sys(clk_sys), .rst(rst), .ce(1'b1), .sck(sck), .csN(csN), .sdi(sdi),
        .sdo(sdo), .sdoEn(sdoEn), .enable(enable), .shutdownRequest(shutdownRequest),
        .bridgeActiveFlag(bridgeActiveFlag), .reactivate(reactivate),
        .mainSupplyUnder(mainSupplyUnder), .diagModeSelect(diagModeSelect),
        .diagModeFull(diagModeFull), .currentLimit(ev[7]), .thermalReduction(ev[6]),
        .overTemp(ev[5]), .shortAcrossLoad(ev[4]), .outAShortToSupply(ev[3]),
        .outAShortToGround(ev[2]), .outBShortToSupply(ev[1]), .outBShortToGround(ev[0]),
        .outASense(outASense), .outBSense(outBSense));

    spi_host_model u_spi_host_model (
        .clk_sys(clk_sys), .sdo(sdo), .sdoEn(sdoEn), .sck(sck), .csN(csN), .sdi(sdi));

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic frame(input logic [7:0] instr, input int n);
        u_spi_host_model.transfer(instr, n, rx, drove);
    endtask

    task automatic diag(input logic [7:0] exp);
        frame(8'h09, 16);
        check(rx, exp);
    endtask

    task automatic pulseEv(input logic [7:0] e);
        ev = e;
        tick(3);
        ev = 8'h00;
        tick(4);
    endtask

    task automatic results();
        if (mismatches == 0 && samplesChecked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            results();
        end
    end

    initial begin
        rst = 1'b1;
        enable = 1'b0;
        shutdownRequest = 1'b0;
        mainSupplyUnder = 1'b0;
        diagModeSelect = 1'b1;
        diagModeFull = 1'b1;
        outASense = 1'b1;
        outBSense = 1'b1;
        ev = 8'h00;
        tick(4);
        rst = 1'b0;
        tick(4);
        check({sdoEn, reactivate, bridgeActiveFlag, 5'h00}, 8'h00);
        foreach (rows[i]) begin
            {enable, shutdownRequest} = rows[i].ctl;
            tick(6);
            frame(8'h09, 16);
            {outASense, outBSense} = rows[i].sense;
            mainSupplyUnder = rows[i].uv;
            pulseEv(rows[i].ev);
            diag(rows[i].exp);
            {outASense, outBSense} = 2'h3;
            mainSupplyUnder = 1'b0;
        end
        frame(8'h00, 16);
        check(rx, ID_VAL);
        frame(8'h03, 16);
        check(rx, {REL_VAL, MASK_VAL});
        frame(8'h05, 16);
        check(rx, 8'hff);
        frame(8'h49, 16);
        check({7'h00, drove}, 8'h00);
        // Short, long and other frames keep faults
        foreach (oddInstr[i]) begin
            pulseEv(8'h08);
            frame(oddInstr[i], oddLen[i]);
            diag(8'hfd);
            diag(8'hff);
        end
        // Undervoltage then recovery
        pulseEv(8'h08);
        mainSupplyUnder = 1'b1;
        tick(8);
        mainSupplyUnder = 1'b0;
        tick(6);
        diag(8'hfd);
        // Mode supply rise
        pulseEv(8'h08);
        diagModeSelect = 1'b0;
        tick(6);
        diagModeSelect = 1'b1;
        tick(6);
        diag(8'hff);
        // Shutdown rise keeps, fall clears
        pulseEv(8'h08);
        shutdownRequest = 1'b1;
        tick(6);
        diag(8'h7d);
        pulseEv(8'h08);
        shutdownRequest = 1'b0;
        tick(6);
        diag(8'hff);
        // Enable toggle clears
        pulseEv(8'h08);
        enable = 1'b0;
        tick(6);
        enable = 1'b1;
        tick(6);
        diag(8'hff);
        // Open load needs serial mode and full mode supply
        enable = 1'b0;
        diagModeFull = 1'b0;
        {outASense, outBSense} = 2'h2;
        tick(6);
        diag(8'h7f);
        diagModeFull = 1'b1;
        diagModeSelect = 1'b0;
        tick(6);
        diag(8'h7f);
        diagModeSelect = 1'b1;
        tick(6);
        diag(8'h73);
        {outASense, outBSense} = 2'h3;
        enable = 1'b1;
        tick(6);
        diag(8'hff);
        results();
    end
endmodule // tb_top

`default_nettype wire
